/* hw/pgd_pkg.sv */
// package for the planar graphics datapath: register indices, fields,
// reset values, mode codes and carrier types.
// assumes a four-plane, byte-wide display memory and an 8/16-bit cpu bus.
package pgd_pkg;

  // ************************************************************
  // register indices
  // ************************************************************
  localparam logic [3:0] PGD_IDX_FILL_VALUE = 4'h0;
  localparam logic [3:0] PGD_IDX_FILL_ENABLE = 4'h1;
  localparam logic [3:0] PGD_IDX_COMPARE_REF = 4'h2;
  localparam logic [3:0] PGD_IDX_ROTATE_FUNC = 4'h3;
  localparam logic [3:0] PGD_IDX_READ_PLANE = 4'h4;
  localparam logic [3:0] PGD_IDX_MODE = 4'h5;
  localparam logic [3:0] PGD_IDX_COMPARE_IGNORE = 4'h7;
  localparam logic [3:0] PGD_IDX_BIT_MASK = 4'h8;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [3:0] PGD_RST_FILL_VALUE = 4'h0;
  localparam logic [3:0] PGD_RST_FILL_ENABLE = 4'h0;
  localparam logic [3:0] PGD_RST_COMPARE_REF = 4'h0;
  localparam logic [4:0] PGD_RST_ROTATE_FUNC = 5'h00;
  localparam logic [1:0] PGD_RST_READ_PLANE = 2'h0;
  localparam logic [6:0] PGD_RST_MODE = 7'h00;
  localparam logic [3:0] PGD_RST_COMPARE_IGNORE = 4'h0;
  localparam logic [7:0] PGD_RST_BIT_MASK = 8'hff;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PGD_ROT_CNT_LSB = 0;
  localparam int PGD_FUNC_LSB = 3;
  localparam int PGD_MODE_WRITE_LSB = 0;
  localparam int PGD_MODE_READ_BIT = 3;
  localparam int PGD_MODE_ODDEVEN_BIT = 4;
  localparam int PGD_MODE_SHIFT_LSB = 5;

  // ************************************************************
  // mode codes
  // ************************************************************
  localparam logic [1:0] PGD_WMODE_0 = 2'h0;
  localparam logic [1:0] PGD_WMODE_1 = 2'h1;
  localparam logic [1:0] PGD_WMODE_2 = 2'h2;
  localparam logic [1:0] PGD_WMODE_3 = 2'h3;
  localparam logic [1:0] PGD_FUNC_PASS = 2'h0;
  localparam logic [1:0] PGD_FUNC_AND = 2'h1;
  localparam logic [1:0] PGD_FUNC_OR = 2'h2;
  localparam logic [1:0] PGD_FUNC_XOR = 2'h3;
  localparam logic [1:0] PGD_SHIFT_LINEAR = 2'h0;
  localparam logic [1:0] PGD_SHIFT_PAIRS = 2'h1;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef logic [3:0][7:0] pgd_planes_t;

  typedef struct packed {
    logic [3:0] fill_value;
    logic [3:0] fill_enable;
    logic [2:0] rot_count;
    logic [1:0] func;
    logic [1:0] write_mode;
    logic [7:0] bit_mask;
  } pgd_write_cfg_t;

  typedef struct packed {
    logic [3:0] we;
    pgd_planes_t data;
  } pgd_mem_lane_t;

endpackage : pgd_pkg

/* hw/pgd_write_lane.sv */
// one byte lane of the write datapath: rotate, fill, logic function, mask.
// assumes latches and configuration are stable for the cycle of use.
`timescale 1ns/1ps
module pgd_write_lane
  import pgd_pkg::*;
(
  input wire logic [7:0] cpu_byte_i, // cpu byte for this lane
  input wire pgd_pkg::pgd_planes_t latch_i, // processor latches
  input wire pgd_pkg::pgd_write_cfg_t cfg_i, // write configuration
  output pgd_pkg::pgd_planes_t plane_o // bytes to write per plane
);
  import pgd_pkg::*;

  logic [7:0] rot;
  logic [15:0] dbl;
  logic [7:0] wm3_mask;

  always_comb
  begin
    dbl = {cpu_byte_i, cpu_byte_i} >> cfg_i.rot_count;  // [RULE4]
    rot = dbl[7:0];
    wm3_mask = rot & cfg_i.bit_mask;  // [RULE11]
  end

  genvar p;
  generate
    for (p = 0; p < 4; p++)
    begin : g_plane
      logic [7:0] src;
      logic [7:0] fn;
      logic [7:0] fill;
      always_comb
      begin
        fill = {8{cfg_i.fill_value[p]}};  // [RULE2]
        if (cfg_i.write_mode == PGD_WMODE_2)
          src = {8{cpu_byte_i[p]}};  // [RULE10]
        else if (cfg_i.fill_enable[p])
          src = fill;  // [RULE1] [RULE3]
        else
          src = rot;  // [RULE1]
        case (cfg_i.func)  // [RULE5]
          PGD_FUNC_AND: fn = src & latch_i[p];
          PGD_FUNC_OR: fn = src | latch_i[p];
          PGD_FUNC_XOR: fn = src ^ latch_i[p];
          default: fn = src;
        endcase
        case (cfg_i.write_mode)
          PGD_WMODE_1: plane_o[p] = latch_i[p];  // [RULE8]
          PGD_WMODE_3:
            plane_o[p] = (wm3_mask & fill) | (~wm3_mask & latch_i[p]);
          default:
            // mask after function so masked pixels keep latches
            plane_o[p] = (fn & cfg_i.bit_mask) |
                         (latch_i[p] & ~cfg_i.bit_mask);  // [RULE18] [RULE19]
        endcase
      end
    end
  endgenerate

endmodule : pgd_write_lane

/* hw/pgd_shifter.sv */
// four 8-bit video shift registers with selectable load pattern.
// assumes load and shift enables come from the character and dot clocks.
`timescale 1ns/1ps
module pgd_shifter
  import pgd_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic reset_i, // sync reset, active high
  input wire logic load_i, // load from planes, pulse
  input wire logic shift_i, // shift one pixel, pulse
  input wire logic [1:0] shift_mode_i, // load pattern select
  input wire pgd_pkg::pgd_planes_t planes_i, // display data from planes
  output logic [3:0] pixel_o // one bit per register
);
  import pgd_pkg::*;

  pgd_planes_t sr_q;
  pgd_planes_t sr_d;
  pgd_planes_t pat;

  genvar n;
  generate
    for (n = 0; n < 4; n++)
    begin : g_reg
      always_comb
      begin
        if (shift_mode_i == PGD_SHIFT_LINEAR)
          pat[n] = planes_i[n];  // [RULE16]
        else if (shift_mode_i == PGD_SHIFT_PAIRS)
          pat[n] = {planes_i[(n / 2) * 2 + 1][(n % 2) + 0],
                    planes_i[(n / 2) * 2 + 1][(n % 2) + 2],
                    planes_i[(n / 2) * 2 + 1][(n % 2) + 4],
                    planes_i[(n / 2) * 2 + 1][(n % 2) + 6],
                    planes_i[(n / 2) * 2][(n % 2) + 0],
                    planes_i[(n / 2) * 2][(n % 2) + 2],
                    planes_i[(n / 2) * 2][(n % 2) + 4],
                    planes_i[(n / 2) * 2][(n % 2) + 6]};  // [RULE16]
        else
          pat[n] = {planes_i[3][n], planes_i[3][n + 4],
                    planes_i[2][n], planes_i[2][n + 4],
                    planes_i[1][n], planes_i[1][n + 4],
                    planes_i[0][n], planes_i[0][n + 4]};  // [RULE16]
        if (load_i)
          sr_d[n] = pat[n];
        else if (shift_i)
          // chained: registers 0-2 fed by the next higher one, register 3 shifts in zero
          sr_d[n] = {sr_q[n][6:0],
                     (n < 3) ? sr_q[(n + 1) % 4][7] : 1'b0};  // [RULE17]
        else
          sr_d[n] = sr_q[n];
        pixel_o[n] = sr_q[n][7];
      end
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      sr_q <= '0;
    else
      sr_q <= sr_d;
  end

endmodule : pgd_shifter

/* hw/pgd_top.sv */
// planar graphics datapath top: indexed registers, cpu read and write
// paths, processor latches and the video shift registers.
// assumes the index register and memory timing live outside; display
// memory returns both byte lanes of all planes combinationally.
//
// What this block does
// (RULE1) write mode 0 writes rotated cpu byte, or enabled fill
// (RULE2) each fill-value bit replicated over its plane byte
// (RULE3) fill-enable picks cpu data or fill, write mode 0 only
// (RULE4) rotate count rotates the write byte right, modes 0 and 3
// (RULE5) function bits pass, and, or, xor data with latches
// (RULE6) read plane select; bit 0 ignored odd/even, both quad
// (RULE7) write mode from mode bits 1-0; word writes work per byte
// (RULE8) write mode 1 writes latches to all planes, ignoring cpu data
// (RULE9) every cpu memory read reloads the four latches
// (RULE10) write mode 2: cpu byte is colour under bit mask, function applies
// (RULE11) write mode 3: rotated byte and bit mask pick fill or latch
// (RULE12) mode bit 3 selects plane read or colour compare read
// (RULE13) compare bit is one when pixel matches reference in cared bits
// (RULE14) word reads compare low and high bytes independently
// (RULE15) mode bit 4 odd/even: even address planes 0,2, odd planes 1,3
// (RULE16) mode bits 6-5 choose the shift register load pattern
// (RULE17) without per-character reload the shift registers form a chain
// (RULE18) bit mask covers all planes: zero keeps latch, one writes data
// (RULE19) in modes 0 and 2 the mask follows the logic function
`timescale 1ns/1ps
module pgd_top
  import pgd_pkg::*;
(
  input wire logic clock_i, // system clock, 100 mhz
  input wire logic reset_i, // sync reset, active high
  input wire logic [3:0] reg_index_i, // register index
  input wire logic reg_we_i, // register write strobe
  input wire logic reg_re_i, // register read strobe
  input wire logic [7:0] reg_wdata_i, // register write data
  output logic [7:0] reg_rdata_o, // register read data
  input wire logic cpu_rd_i, // cpu memory read, pulse
  input wire logic cpu_wr_i, // cpu memory write, pulse
  input wire logic cpu_word_i, // 16-bit access
  input wire logic [1:0] cpu_addr_i, // low cpu address bits
  input wire logic [15:0] cpu_wdata_i, // cpu write data
  output logic [15:0] cpu_rdata_o, // cpu read data
  output logic cpu_rvalid_o, // read data valid, pulse
  input wire logic quad_mode_i, // sequencer quad mode
  input wire pgd_pkg::pgd_planes_t mem_lo_i, // planes, even byte
  input wire pgd_pkg::pgd_planes_t mem_hi_i, // planes, odd byte
  output pgd_pkg::pgd_mem_lane_t mem_wr_lo_o, // plane writes, low lane
  output pgd_pkg::pgd_mem_lane_t mem_wr_hi_o, // plane writes, high lane
  output logic [31:0] latch_o, // processor latches
  input wire pgd_pkg::pgd_planes_t video_i, // display fetch data
  input wire logic char_load_i, // character load, pulse
  input wire logic dot_shift_i, // dot shift, pulse
  output logic [3:0] pixel_o // video shift output
);
  import pgd_pkg::*;

  // ************************************************************
  // indexed registers
  // ************************************************************
  logic [3:0] fill_value_q;
  logic [3:0] fill_value_d;
  logic [3:0] fill_enable_q;
  logic [3:0] fill_enable_d;
  logic [3:0] compare_ref_q;
  logic [3:0] compare_ref_d;
  logic [4:0] rotate_func_q;
  logic [4:0] rotate_func_d;
  logic [1:0] read_plane_q;
  logic [1:0] read_plane_d;
  logic [6:0] mode_q;
  logic [6:0] mode_d;
  logic [3:0] compare_ignore_q;
  logic [3:0] compare_ignore_d;
  logic [7:0] bit_mask_q;
  logic [7:0] bit_mask_d;
  logic [7:0] reg_rdata_q;
  logic [7:0] reg_rdata_d;

  always_comb
  begin
    fill_value_d = fill_value_q;
    fill_enable_d = fill_enable_q;
    compare_ref_d = compare_ref_q;
    rotate_func_d = rotate_func_q;
    read_plane_d = read_plane_q;
    mode_d = mode_q;
    compare_ignore_d = compare_ignore_q;
    bit_mask_d = bit_mask_q;
    if (reg_we_i)
    begin
      if (reg_index_i == PGD_IDX_FILL_VALUE)
        fill_value_d = reg_wdata_i[3:0];
      else if (reg_index_i == PGD_IDX_FILL_ENABLE)
        fill_enable_d = reg_wdata_i[3:0];
      else if (reg_index_i == PGD_IDX_COMPARE_REF)
        compare_ref_d = reg_wdata_i[3:0];
      else if (reg_index_i == PGD_IDX_ROTATE_FUNC)
        rotate_func_d = reg_wdata_i[4:0];
      else if (reg_index_i == PGD_IDX_READ_PLANE)
        read_plane_d = reg_wdata_i[1:0];
      else if (reg_index_i == PGD_IDX_MODE)
        mode_d = {reg_wdata_i[6:3], 1'b0, reg_wdata_i[1:0]};
      else if (reg_index_i == PGD_IDX_COMPARE_IGNORE)
        compare_ignore_d = reg_wdata_i[3:0];
      else if (reg_index_i == PGD_IDX_BIT_MASK)
        bit_mask_d = reg_wdata_i;
    end
    // reserved bits read as zero; unknown index reads zero
    reg_rdata_d = reg_rdata_q;
    if (reg_re_i)
    begin
      if (reg_index_i == PGD_IDX_FILL_VALUE)
        reg_rdata_d = {4'h0, fill_value_q};
      else if (reg_index_i == PGD_IDX_FILL_ENABLE)
        reg_rdata_d = {4'h0, fill_enable_q};
      else if (reg_index_i == PGD_IDX_COMPARE_REF)
        reg_rdata_d = {4'h0, compare_ref_q};
      else if (reg_index_i == PGD_IDX_ROTATE_FUNC)
        reg_rdata_d = {3'h0, rotate_func_q};
      else if (reg_index_i == PGD_IDX_READ_PLANE)
        reg_rdata_d = {6'h00, read_plane_q};
      else if (reg_index_i == PGD_IDX_MODE)
        reg_rdata_d = {1'b0, mode_q};
      else if (reg_index_i == PGD_IDX_COMPARE_IGNORE)
        reg_rdata_d = {4'h0, compare_ignore_q};
      else if (reg_index_i == PGD_IDX_BIT_MASK)
        reg_rdata_d = bit_mask_q;
      else
        reg_rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      fill_value_q <= PGD_RST_FILL_VALUE;
      fill_enable_q <= PGD_RST_FILL_ENABLE;
      compare_ref_q <= PGD_RST_COMPARE_REF;
      rotate_func_q <= PGD_RST_ROTATE_FUNC;
      read_plane_q <= PGD_RST_READ_PLANE;
      mode_q <= PGD_RST_MODE;
      compare_ignore_q <= PGD_RST_COMPARE_IGNORE;
      bit_mask_q <= PGD_RST_BIT_MASK;
      reg_rdata_q <= 8'h00;
    end
    else
    begin
      fill_value_q <= fill_value_d;
      fill_enable_q <= fill_enable_d;
      compare_ref_q <= compare_ref_d;
      rotate_func_q <= rotate_func_d;
      read_plane_q <= read_plane_d;
      mode_q <= mode_d;
      compare_ignore_q <= compare_ignore_d;
      bit_mask_q <= bit_mask_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  assign reg_rdata_o = reg_rdata_q;

  // ************************************************************
  // decoded mode fields
  // ************************************************************
  logic [1:0] write_mode;
  logic read_compare;
  logic odd_even;
  logic [1:0] shift_mode;
  pgd_write_cfg_t cfg;

  always_comb
  begin
    write_mode = mode_q[PGD_MODE_WRITE_LSB +: 2];  // [RULE7]
    read_compare = mode_q[PGD_MODE_READ_BIT];  // [RULE12]
    odd_even = mode_q[PGD_MODE_ODDEVEN_BIT];  // [RULE15]
    shift_mode = mode_q[PGD_MODE_SHIFT_LSB +: 2];  // [RULE16]
    cfg.fill_value = fill_value_q;
    // fill enable only counts in write mode 0
    cfg.fill_enable = (write_mode == PGD_WMODE_0) ?
                      fill_enable_q : 4'h0;  // [RULE3]
    cfg.rot_count = rotate_func_q[PGD_ROT_CNT_LSB +: 3];  // [RULE4]
    cfg.func = (write_mode == PGD_WMODE_3) ?
               PGD_FUNC_PASS : rotate_func_q[PGD_FUNC_LSB +: 2];  // [RULE5]
    cfg.write_mode = write_mode;
    cfg.bit_mask = bit_mask_q;
  end

  // ************************************************************
  // processor latches
  // ************************************************************
  pgd_planes_t latch_q;
  pgd_planes_t latch_d;

  always_comb
  begin
    latch_d = latch_q;
    if (cpu_rd_i)
      latch_d = cpu_addr_i[0] ? mem_hi_i : mem_lo_i;  // [RULE9]
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      latch_q <= '0;
    else
      latch_q <= latch_d;
  end

  assign latch_o = latch_q;

  // ************************************************************
  // write path
  // ************************************************************
  pgd_planes_t wr_lo;
  pgd_planes_t wr_hi;
  pgd_mem_lane_t wr_lo_q;
  pgd_mem_lane_t wr_lo_d;
  pgd_mem_lane_t wr_hi_q;
  pgd_mem_lane_t wr_hi_d;
  logic [3:0] planes_even;
  logic [3:0] planes_odd;

  pgd_write_lane u_lane_lo (
    .cpu_byte_i(cpu_wdata_i[7:0]),
    .latch_i(latch_q),
    .cfg_i(cfg),
    .plane_o(wr_lo)
  );

  // word writes repeat the operation on the high byte
  pgd_write_lane u_lane_hi (
    .cpu_byte_i(cpu_wdata_i[15:8]),
    .latch_i(latch_q),
    .cfg_i(cfg),
    .plane_o(wr_hi)
  );  // [RULE7]

  always_comb
  begin
    planes_even = odd_even ? 4'h5 : 4'hf;  // [RULE15]
    planes_odd = odd_even ? 4'ha : 4'hf;  // [RULE15]
    wr_lo_d.data = wr_lo;
    wr_hi_d.data = wr_hi;
    wr_lo_d.we = 4'h0;
    wr_hi_d.we = 4'h0;
    if (cpu_wr_i)
    begin
      if (cpu_word_i)
      begin
        wr_lo_d.we = planes_even;
        wr_hi_d.we = planes_odd;
      end
      else if (cpu_addr_i[0])
        wr_hi_d.we = planes_odd;
      else
        wr_lo_d.we = planes_even;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      wr_lo_q <= '0;
      wr_hi_q <= '0;
    end
    else
    begin
      wr_lo_q <= wr_lo_d;
      wr_hi_q <= wr_hi_d;
    end
  end

  assign mem_wr_lo_o = wr_lo_q;
  assign mem_wr_hi_o = wr_hi_q;

  // ************************************************************
  // read path
  // ************************************************************
  logic [1:0] plane_lo;
  logic [1:0] plane_hi;
  logic [7:0] cmp_lo;
  logic [7:0] cmp_hi;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  always_comb
  begin
    if (quad_mode_i)
    begin
      plane_lo = cpu_addr_i;  // [RULE6]
      plane_hi = cpu_addr_i + 2'h1;
    end
    else if (odd_even)
    begin
      plane_lo = {read_plane_q[1], 1'b0};  // [RULE6]
      plane_hi = {read_plane_q[1], 1'b1};
    end
    else
    begin
      plane_lo = read_plane_q;  // [RULE6]
      plane_hi = read_plane_q;
    end
  end

  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_cmp
      always_comb
      begin
        cmp_lo[b] = ~|(({mem_lo_i[3][b], mem_lo_i[2][b], mem_lo_i[1][b],
                         mem_lo_i[0][b]} ^ compare_ref_q) &
                       compare_ignore_q);  // [RULE13]
        cmp_hi[b] = ~|(({mem_hi_i[3][b], mem_hi_i[2][b], mem_hi_i[1][b],
                         mem_hi_i[0][b]} ^ compare_ref_q) &
                       compare_ignore_q);  // [RULE13] [RULE14]
      end
    end
  endgenerate

  always_comb
  begin
    rdata_d = rdata_q;
    rvalid_d = cpu_rd_i;
    if (cpu_rd_i)
    begin
      if (read_compare)
        rdata_d = {cmp_hi, cmp_lo};  // [RULE12] [RULE14]
      else
        rdata_d = {mem_hi_i[plane_hi], mem_lo_i[plane_lo]};  // [RULE12]
      if (!cpu_word_i && cpu_addr_i[0])
        rdata_d[7:0] = rdata_d[15:8];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign cpu_rdata_o = rdata_q;
  assign cpu_rvalid_o = rvalid_q;

  // ************************************************************
  // video shift registers
  // ************************************************************
  pgd_shifter u_shifter (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .load_i(char_load_i),
    .shift_i(dot_shift_i),
    .shift_mode_i(shift_mode),
    .planes_i(video_i),
    .pixel_o(pixel_o)
  );  // [RULE16] [RULE17]

endmodule : pgd_top

/* testbench/pgd_props.sv */
// checker for the datapath top: read, write and latch timing.
// assumes a bind from the bench top and one clock domain.
`timescale 1ns/1ps
module pgd_props
  import pgd_pkg::*;
(
  input wire logic clock_i, // clock
  input wire logic reset_i, // reset
  input wire logic [3:0] reg_index_i, // index
  input wire logic reg_we_i, // reg write
  input wire logic reg_re_i, // reg read
  input wire logic [7:0] reg_wdata_i, // reg data
  input wire logic [7:0] reg_rdata_o, // reg read data
  input wire logic cpu_rd_i, // cpu read
  input wire logic cpu_wr_i, // cpu write
  input wire logic cpu_word_i, // word
  input wire logic [1:0] cpu_addr_i, // address
  input wire logic [15:0] cpu_rdata_o, // read data
  input wire logic cpu_rvalid_o, // read valid
  input wire logic quad_mode_i, // quad
  input wire pgd_pkg::pgd_planes_t mem_lo_i, // even planes
  input wire pgd_pkg::pgd_mem_lane_t mem_wr_lo_o, // low writes
  input wire pgd_pkg::pgd_mem_lane_t mem_wr_hi_o, // high writes
  input wire logic [31:0] latch_o // latches
);
  logic [7:0] mode_q;
  logic [1:0] sel_q;
  logic [7:0] pick;
  assign pick = mem_lo_i[sel_q];
  // shadow of mode and plane select
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      mode_q <= 8'h00;
      sel_q <= 2'h0;
    end
    else if (reg_we_i && reg_index_i == 4'h5)
      mode_q <= reg_wdata_i;
    else if (reg_we_i && reg_index_i == 4'h4)
      sel_q <= reg_wdata_i[1:0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_rvalid_follows: assert property (cpu_rd_i |=> cpu_rvalid_o)
    else $error("read valid missing");
  a_rvalid_quiet: assert property (!cpu_rd_i |=> !cpu_rvalid_o)
    else $error("read valid without read");
  a_latch_reload: assert property (cpu_rd_i && !cpu_addr_i[0]
    |=> latch_o == $past(mem_lo_i)) else $error("latches not reloaded");
  a_lanes_all: assert property (cpu_wr_i && cpu_word_i && !mode_q[4]
    |=> mem_wr_lo_o.we == 4'hf && mem_wr_hi_o.we == 4'hf)
    else $error("word write misses planes");
  a_lanes_oddeven: assert property (cpu_wr_i && cpu_word_i && mode_q[4]
    |=> mem_wr_lo_o.we == 4'h5 && mem_wr_hi_o.we == 4'ha)
    else $error("odd even planes wrong");
  a_we_idle: assert property (!cpu_wr_i
    |=> mem_wr_lo_o.we == 4'h0 && mem_wr_hi_o.we == 4'h0)
    else $error("plane write without cpu write");
  a_latch_write: assert property (cpu_wr_i && mode_q[1:0] == 2'h1
    && (cpu_word_i || !cpu_addr_i[0])
    |=> mem_wr_lo_o.data == $past(latch_o)) else $error("mode 1 data");
  a_plane_read: assert property (cpu_rd_i && !mode_q[3] && !mode_q[4]
    && !quad_mode_i && !cpu_addr_i[0] |=> cpu_rdata_o[7:0] == $past(pick))
    else $error("plane read wrong");
  a_unknown_zero: assert property (reg_re_i && reg_index_i == 4'h6
    |=> reg_rdata_o == 8'h00) else $error("unmapped index not zero");
endmodule : pgd_props

/* testbench/pgd_mem_model.sv */
// display memory model: one byte per plane for each byte lane.
// assumes plane writes arrive as one-cycle enables.
`timescale 1ns/1ps
module pgd_mem_model
  import pgd_pkg::*;
#(
  parameter pgd_planes_t INIT_LO = '0,
  parameter pgd_planes_t INIT_HI = '0
)
(
  input wire logic clock_i, // clock
  input wire pgd_pkg::pgd_mem_lane_t wr_lo_i, // even writes
  input wire pgd_pkg::pgd_mem_lane_t wr_hi_i, // odd writes
  output pgd_pkg::pgd_planes_t lo_o, // even planes
  output pgd_pkg::pgd_planes_t hi_o // odd planes
);
  pgd_planes_t lo_q = INIT_LO;
  pgd_planes_t hi_q = INIT_HI;
  assign lo_o = lo_q;
  assign hi_o = hi_q;
  always_ff @(posedge clock_i)
  begin
    for (int p = 0; p < 4; p++)
    begin
      if (wr_lo_i.we[p])
        lo_q[p] <= wr_lo_i.data[p];
      if (wr_hi_i.we[p])
        hi_q[p] <= wr_hi_i.data[p];
    end
  end
endmodule : pgd_mem_model

/* testbench/pgd_top_tb.sv */
// self-checking bench for the planar graphics datapath.
// assumes the memory model answers reads in the same cycle.
`timescale 1ns/1ps
module pgd_top_tb;
  import pgd_pkg::*;
  localparam pgd_planes_t LO = 32'h0fc35a96;
  localparam pgd_planes_t HI = 32'h8124e73c;
  localparam pgd_planes_t VID = 32'h12b4e19c;
  logic clock_i = 0, reset_i = 1, reg_we_i = 0, reg_re_i = 0;
  logic cpu_rd_i = 0, cpu_wr_i = 0, cpu_word_i = 0, quad_mode_i = 0;
  logic char_load_i = 0, dot_shift_i = 0, cpu_rvalid_o;
  logic [3:0] reg_index_i = 4'h0, pixel_o, fv, fe;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, bm;
  logic [1:0] cpu_addr_i = 2'h0, fn;
  logic [2:0] rc;
  logic [15:0] cpu_wdata_i = 16'h0000, cpu_rdata_o;
  logic [31:0] latch_o;
  pgd_planes_t mem_lo_i, mem_hi_i, lt;
  pgd_planes_t video_i = VID;
  pgd_mem_lane_t mem_wr_lo_o, mem_wr_hi_o;
  int fail_count = 0, checks = 0, cycles = 0;
  pgd_top pgd_top_inst (.*);
  pgd_mem_model #(.INIT_LO(LO), .INIT_HI(HI)) pgd_mem_model_inst (.clock_i,
    .wr_lo_i(mem_wr_lo_o), .wr_hi_i(mem_wr_hi_o), .lo_o(mem_lo_i),
    .hi_o(mem_hi_i));
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    if (++cycles == 2000)
    begin
      fail_count++;
      close_out();
    end
  end
  // ************************************************************
  // bus tasks and reference models
  // ************************************************************
  task automatic cyc();
    @(posedge clock_i);
    #1;
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rw(input logic [3:0] i, input logic [7:0] d);
    cyc();
    reg_index_i = i;
    reg_wdata_i = d;
    reg_we_i = 1;
    cyc();
    reg_we_i = 0;
  endtask : rw
  task automatic rr(input logic [3:0] i, input logic [7:0] e);
    cyc();
    reg_index_i = i;
    reg_re_i = 1;
    cyc();
    reg_re_i = 0;
    chk(reg_rdata_o, e);
  endtask : rr
  task automatic acc(input logic w, rd, input logic [1:0] a,
    input logic [15:0] d);
    cyc();
    cpu_word_i = w;
    cpu_addr_i = a;
    cpu_wdata_i = d;
    cpu_rd_i = rd;
    cpu_wr_i = !rd;
    cyc();
    cpu_rd_i = 0;
    cpu_wr_i = 0;
  endtask : acc
  task automatic cfg(input logic [1:0] m, input logic [3:0] v, e,
    input logic [2:0] r, input logic [1:0] f, input logic [7:0] k);
    fv = v;
    fe = e;
    rc = r;
    fn = f;
    bm = k;
    rw(4'h0, v);
    rw(4'h1, e);
    rw(4'h3, {f, r});
    rw(4'h5, m);
    rw(4'h8, k);
  endtask : cfg
  function automatic pgd_planes_t ew(input logic [1:0] m, input logic [7:0] b);
    logic [7:0] r, d, k;
    r = 8'({b, b} >> rc);
    k = (m == 2'h3) ? (r & bm) : bm;
    for (int p = 0; p < 4; p++)
    begin
      d = (m == 2'h2) ? {8{b[p]}} : (fe[p] && m == 2'h0) ? {8{fv[p]}} : r;
      if (m != 2'h3)
        d = fn == 1 ? d & lt[p] : fn == 2 ? d | lt[p] : fn == 3 ? d ^ lt[p] : d;
      else
        d = {8{fv[p]}};
      ew[p] = (m == 2'h1) ? lt[p] : (d & k) | (lt[p] & ~k);
    end
  endfunction : ew
  function automatic logic [7:0] cmp(input pgd_planes_t pl);
    for (int i = 0; i < 8; i++)
      cmp[i] = &(~({pl[3][i], pl[2][i], pl[1][i], pl[0][i]} ^ 4'h5) | 4'h2);
  endfunction : cmp
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    logic [7:0] msk [9] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b, 8'h00,
      8'h0f, 8'hff};
    for (int i = 0; i < 9; i++)
      rr(4'(i), i == 8 ? 8'hff : 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      rw(4'(i), 8'hff);
      rr(4'(i), msk[i]);
    end
    $display("regs done");
  endtask : t_regs
  task automatic t_read();
    rw(4'h5, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      rw(4'h4, 8'(s));
      acc(0, 1, 2'h0, 16'h0);
      chk(cpu_rdata_o[7:0], LO[s]);
      chk(latch_o, LO);
    end
    rw(4'h5, 8'h10);
    rw(4'h4, 8'h02);
    acc(0, 1, 2'h1, 16'h0);
    chk(cpu_rdata_o[7:0], HI[3]);
    chk(latch_o, HI);
    quad_mode_i = 1;
    rw(4'h5, 8'h00);
    rw(4'h4, 8'h00);
    acc(0, 1, 2'h2, 16'h0);
    chk(cpu_rdata_o[7:0], LO[2]);
    quad_mode_i = 0;
    rw(4'h2, 8'h05);
    rw(4'h7, 8'h0d);
    rw(4'h5, 8'h08);
    acc(1, 1, 2'h0, 16'h0);
    chk(cpu_rdata_o, {cmp(HI), cmp(LO)});
    $display("read done");
  endtask : t_read
  task automatic t_write();
    lt = LO;
    cfg(2'h0, 4'ha, 4'h3, 3'h3, 2'h0, 8'hf0);
    acc(1, 0, 2'h0, 16'h5ac3);
    chk(mem_wr_lo_o.data, ew(2'h0, 8'hc3));
    chk(mem_wr_hi_o.data, ew(2'h0, 8'h5a));
    for (int f = 0; f < 4; f++)
    begin
      cfg(2'h0, 4'ha, 4'h0, 3'h5, 2'(f), 8'h3c);
      acc(0, 0, 2'h0, 16'h00b7);
      chk(mem_wr_lo_o.data, ew(2'h0, 8'hb7));
    end
    cfg(2'h1, 4'h5, 4'hf, 3'h1, 2'h3, 8'h00);
    acc(1, 0, 2'h0, 16'hffff);
    chk({mem_wr_hi_o.data, mem_wr_lo_o.data}, {lt, lt});
    cfg(2'h2, 4'ha, 4'hf, 3'h2, 2'h1, 8'h66);
    acc(0, 0, 2'h1, 16'h0900);
    chk(mem_wr_hi_o.data, ew(2'h2, 8'h09));
    chk({mem_wr_lo_o.we, mem_wr_hi_o.we}, 8'h0f);
    cfg(2'h3, 4'h6, 4'hf, 3'h1, 2'h3, 8'hdb);
    acc(0, 0, 2'h0, 16'h00a5);
    chk(mem_wr_lo_o.data, ew(2'h3, 8'ha5));
    rw(4'h5, 8'h10);
    acc(1, 0, 2'h0, 16'h1234);
    chk({mem_wr_lo_o.we, mem_wr_hi_o.we}, 8'h5a);
    $display("write done");
  endtask : t_write
  task automatic t_video();
    rw(4'h5, 8'h00);
    char_load_i = 1;
    cyc();
    char_load_i = 0;
    chk(pixel_o, {VID[3][7], VID[2][7], VID[1][7], VID[0][7]});
    dot_shift_i = 1;
    repeat (8) cyc();
    dot_shift_i = 0;
    chk(pixel_o, {1'b0, VID[3][7], VID[2][7], VID[1][7]});
    rw(4'h5, 8'h40);
    char_load_i = 1;
    cyc();
    char_load_i = 0;
    chk(pixel_o, VID[3][3:0]);
    $display("video done");
  endtask : t_video
  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (6) cyc();
    reset_i = 0;
    t_regs();
    t_read();
    t_write();
    t_video();
    close_out();
  end
endmodule : pgd_top_tb
bind pgd_top pgd_props pgd_props_inst (.*);
